// File: include/dec_params.svh
`ifndef DEC_PARAMS_SVH
`define DEC_PARAMS_SVH
// ----------------------------------------
// bit numbering: bit 0 is the msb
// ----------------------------------------
`define DEC_B(n) (31-(n))
// ----------------------------------------
// register select codes
// ----------------------------------------
`define DEC_SEL_CTRL_A 4'h0
`define DEC_SEL_CTRL_B 4'h1
`define DEC_SEL_STATUS 4'h2
`define DEC_SEL_FETCH_ADDR_CMP_1 4'h3
`define DEC_SEL_FETCH_ADDR_CMP_2 4'h4
`define DEC_SEL_FETCH_ADDR_CMP_3 4'h5
`define DEC_SEL_FETCH_ADDR_CMP_4 4'h6
`define DEC_SEL_DATA_ADDR_CMP_1 4'h7
`define DEC_SEL_DATA_ADDR_CMP_2 4'h8
`define DEC_SEL_VALUE_CMP_WORD_1 4'h9
`define DEC_SEL_VALUE_CMP_WORD_2 4'ha
// ----------------------------------------
// event_control_a fields
// ----------------------------------------
`define DEC_A_EXT 0
`define DEC_A_INT 1
`define DEC_A_IC 4
`define DEC_A_BT 5
`define DEC_A_EXC 6
`define DEC_A_TRAP 7
`define DEC_A_IA1 8
`define DEC_A_IA2 9
`define DEC_A_RA 10
`define DEC_A_RAX 11
`define DEC_A_IA3 12
`define DEC_A_IA4 13
`define DEC_A_RB 14
`define DEC_A_RBX 15
`define DEC_A_RAT 16
`define DEC_A_RBT 17
`define DEC_A_FT 31
// ----------------------------------------
// event_control_b fields
// ----------------------------------------
`define DEC_B_D1R 0
`define DEC_B_D2R 1
`define DEC_B_D1W 2
`define DEC_B_D2W 3
`define DEC_B_D1S 4
`define DEC_B_D2S 6
`define DEC_B_DA 8
`define DEC_B_DAX 9
`define DEC_B_VALUE_CMP1_MODE 12
`define DEC_B_VALUE_CMP2_MODE 14
`define DEC_B_VALUE_CMP1_LANES 16
`define DEC_B_VALUE_CMP2_LANES 20
// ----------------------------------------
// event_status fields
// ----------------------------------------
`define DEC_S_IC 0
`define DEC_S_BT 1
`define DEC_S_EXC 2
`define DEC_S_TRAP 3
`define DEC_S_FORCED 4
`define DEC_S_IA1 5
`define DEC_S_IA2 6
`define DEC_S_DR1 7
`define DEC_S_DW1 8
`define DEC_S_DR2 9
`define DEC_S_DW2 10
`define DEC_S_IMP 11
`define DEC_S_IA3 12
`define DEC_S_IA4 13
`define DEC_S_MRR 22
// ----------------------------------------
// masks, codes, reset values
// ----------------------------------------
`define DEC_WORD_MASK 32'hffff_fffc
`define DEC_CTRL_A_MASK 32'hffff_c001
`define DEC_CTRL_B_MASK 32'hffff_ff00
`define DEC_ZERO_WORD 32'h0000_0000
`define DEC_MASK_BYTE 32'hffff_ffff
`define DEC_MASK_HALF 32'hffff_fffe
`define DEC_MASK_WORD 32'hffff_fffc
`define DEC_MASK_LINE 32'hffff_ffe0
`define DEC_SIZE_BYTE 2'h0
`define DEC_SIZE_HALF 2'h1
`define DEC_SIZE_WORD 2'h2
`define DEC_VMODE_NONE 2'h0
`define DEC_VMODE_AND 2'h1
`define DEC_VMODE_OR 2'h2
`define DEC_VMODE_HALF 2'h3
`endif

// File: include/dec_pkg.sv
package dec_pkg;
  typedef logic [31:0] dec_word_t;
  typedef struct packed {
    dec_word_t ctrl_a;
    dec_word_t ctrl_b;
    dec_word_t status;
    logic [3:0][31:0] iac;
    logic [1:0][31:0] dac;
    logic [1:0][31:0] dvc;
    dec_word_t rdata;
    logic intr;
    logic stop;
    logic wstop;
    logic freeze;
    logic [2:0] sync;
    logic forced_lvl;
  } dec_state_t;
endpackage : dec_pkg

// File: hw/dec_value_cmp.sv
`timescale 1ns/1ps
`include "dec_params.svh"
module dec_value_cmp
  import dec_pkg::*;
(
  // operands
  input wire logic [31:0] data,
  input wire logic [31:0] ref_word,
  // configuration
  input wire logic [3:0] lanes,
  input wire logic [1:0] mode,
  // result
  output logic match
);
  logic [3:0] eq;
  logic hi_ok;
  logic lo_ok;

  // ----------------------------------------
  // per byte equality
  // ----------------------------------------
  genvar g;
  for (g = 0; g < 4; g++) begin : g_lane
    assign eq[g] = data[8*g +: 8] == ref_word[8*g +: 8];
  end

  assign hi_ok = lanes[3] & lanes[2] & eq[3] & eq[2];
  assign lo_ok = lanes[1] & lanes[0] & eq[1] & eq[0];

  // ----------------------------------------
  // mode select
  // ----------------------------------------
  always_comb begin
    unique case (mode)
      `DEC_VMODE_AND: match = &(eq | ~lanes);
      `DEC_VMODE_OR: match = |(eq & lanes);
      `DEC_VMODE_HALF: match = hi_ok | lo_ok;
      `DEC_VMODE_NONE: match = 1'b1;
    endcase
  end
endmodule : dec_value_cmp

// File: hw/dec_event_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - control a enables exception, trap, fetch compares
// - bit 10 makes fetch 1-2 a range
// - bit 11 selects range 1-2 exclusive
// - bits 14/15 range and exclusive for 3-4
// - toggle bits flip exclusive on fetch event
// - bit 31 freezes timers on event
// - control b read/write data compare enables
// - compare 1 size masks low address bits
// - compare 2 size masks the same way
// - bits 8/9 data range and exclusive
// - value 1 mode: and, or, halfword
// - value 2 mode uses same encodings
// - lane enables pick compared data bytes
// - status write is a clear mask
// - status flags set by their events
// - bit 11 records event while disallowed
// - bits 22:23 record latest reset kind
// - fetch compares use word address only
// - errors suppress data events, cache ops suppress value compare matches
// - value event needs address and value match
// - action depends on debug mode
// - bits 0/1 external and internal mode
// - bits 4/5 completion and branch enables
// - interrupt needs internal mode and allow
`include "dec_params.svh"
module dec_event_ctrl
  import dec_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [1:0] RESET_KIND,
  // register access
  input wire logic REG_WR,
  input wire logic [3:0] REG_SEL,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  // instruction side
  input wire logic FETCH_VALID,
  input wire logic [31:0] FETCH_ADDR,
  input wire logic INSTR_DONE,
  input wire logic BRANCH_TAKEN,
  input wire logic EXC_TAKEN,
  input wire logic EXC_CRITICAL,
  input wire logic TRAP_TAKEN,
  input wire logic FORCED_EVENT_INPUT,
  // data side
  input wire logic DATA_VALID,
  input wire logic DATA_WRITE,
  input wire logic DATA_CACHE_OP,
  input wire logic DATA_ERROR,
  input wire logic [31:0] DATA_ADDR,
  input wire logic [31:0] DATA_VALUE,
  // processor state
  input wire logic DBG_INTR_ALLOW,
  input wire logic WAIT_MODE_EN,
  input wire logic DBG_INTR_ACK,
  input wire logic RESUME,
  input wire logic EXT_INTR,
  // actions
  output logic DBG_INTR_REQ,
  output logic CORE_STOP,
  output logic TIMER_FREEZE
);
  dec_state_t q;
  dec_state_t d;

  // ----------------------------------------
  // control fields
  // ----------------------------------------
  logic ext_mode;
  logic int_mode;
  logic de;
  logic quiet;
  logic flip_a;
  logic flip_b;
  logic range_a_en;
  logic range_b_en;
  logic [1:0] size1;
  logic [1:0] size2;

  assign ext_mode = q.ctrl_a[`DEC_B(`DEC_A_EXT)];
  assign int_mode = q.ctrl_a[`DEC_B(`DEC_A_INT)];
  assign de = DBG_INTR_ALLOW;
  assign quiet = int_mode & ~ext_mode & ~de;
  assign flip_a = q.ctrl_a[`DEC_B(`DEC_A_RAT)];
  assign flip_b = q.ctrl_a[`DEC_B(`DEC_A_RBT)];
  assign range_a_en = q.ctrl_a[`DEC_B(`DEC_A_RA)];
  assign range_b_en = q.ctrl_a[`DEC_B(`DEC_A_RB)];
  assign size1 = q.ctrl_b[`DEC_B(`DEC_B_D1S) -: 2];
  assign size2 = q.ctrl_b[`DEC_B(`DEC_B_D2S) -: 2];

  // ----------------------------------------
  // range gating
  // ----------------------------------------
  logic gate_a;
  logic gate_b;

  assign gate_a = ~(flip_a & quiet);
  assign gate_b = ~(flip_b & quiet);

  // ----------------------------------------
  // instruction address compare
  // ----------------------------------------
  logic [31:0] fa;
  logic [3:0] ia_eq;
  logic [3:0] ia_en;
  logic [3:0] ia_hit;
  logic in_a;
  logic in_b;
  logic hit_a;
  logic hit_b;

  assign fa = FETCH_ADDR & `DEC_WORD_MASK;
  assign ia_en[0] = q.ctrl_a[`DEC_B(`DEC_A_IA1)];
  assign ia_en[1] = q.ctrl_a[`DEC_B(`DEC_A_IA2)];
  assign ia_en[2] = q.ctrl_a[`DEC_B(`DEC_A_IA3)];
  assign ia_en[3] = q.ctrl_a[`DEC_B(`DEC_A_IA4)];
  assign in_a = (fa >= q.iac[0]) && (fa < q.iac[1]);
  assign in_b = (fa >= q.iac[2]) && (fa < q.iac[3]);
  assign hit_a = (q.ctrl_a[`DEC_B(`DEC_A_RAX)] ? ~in_a : in_a) & gate_a;
  assign hit_b = (q.ctrl_a[`DEC_B(`DEC_A_RBX)] ? ~in_b : in_b) & gate_b;

  genvar i;
  for (i = 0; i < 4; i++) begin : g_iac
    logic rng;
    assign rng = (i < 2) ? range_a_en : range_b_en;
    assign ia_eq[i] = fa == q.iac[i];
    assign ia_hit[i] = FETCH_VALID & ia_en[i] & (rng ? ((i < 2) ? hit_a : hit_b) : ia_eq[i]);
  end

  // ----------------------------------------
  // data address compare
  // ----------------------------------------
  function automatic logic [31:0] size_mask(input logic [1:0] sz);
    logic [31:0] m;
    unique case (sz)
      `DEC_SIZE_BYTE: m = `DEC_MASK_BYTE;
      `DEC_SIZE_HALF: m = `DEC_MASK_HALF;
      `DEC_SIZE_WORD: m = `DEC_MASK_WORD;
      default: m = `DEC_MASK_LINE;
    endcase
    return m;
  endfunction : size_mask

  logic [31:0] m1;
  logic [31:0] m2;
  logic d_in;
  logic d_rng;
  logic a1;
  logic a2;
  logic [1:0] vmode1;
  logic [1:0] vmode2;
  logic vm1;
  logic vm2;
  logic v1ok;
  logic v2ok;
  logic dok;
  logic rd;
  logic wr;

  assign m1 = size_mask(size1);
  assign m2 = size_mask(size2);
  assign d_in = (DATA_ADDR >= q.dac[0]) && (DATA_ADDR < q.dac[1]);
  assign d_rng = q.ctrl_b[`DEC_B(`DEC_B_DAX)] ? ~d_in : d_in;
  assign a1 = q.ctrl_b[`DEC_B(`DEC_B_DA)] ? d_rng : ((DATA_ADDR & m1) == (q.dac[0] & m1));
  assign a2 = q.ctrl_b[`DEC_B(`DEC_B_DA)] ? d_rng : ((DATA_ADDR & m2) == (q.dac[1] & m2));
  assign vmode1 = q.ctrl_b[`DEC_B(`DEC_B_VALUE_CMP1_MODE) -: 2];
  assign vmode2 = q.ctrl_b[`DEC_B(`DEC_B_VALUE_CMP2_MODE) -: 2];

  // ----------------------------------------
  // data value compare
  // ----------------------------------------
  dec_value_cmp u_vc1 (
    .data(DATA_VALUE),
    .ref_word(q.dvc[0]),
    .lanes(q.ctrl_b[`DEC_B(`DEC_B_VALUE_CMP1_LANES) -: 4]),
    .mode(vmode1),
    .match(vm1)
  );

  dec_value_cmp u_vc2 (
    .data(DATA_VALUE),
    .ref_word(q.dvc[1]),
    .lanes(q.ctrl_b[`DEC_B(`DEC_B_VALUE_CMP2_LANES) -: 4]),
    .mode(vmode2),
    .match(vm2)
  );

  assign v1ok = (vmode1 == `DEC_VMODE_NONE) | (vm1 & ~DATA_CACHE_OP);
  assign v2ok = (vmode2 == `DEC_VMODE_NONE) | (vm2 & ~DATA_CACHE_OP);
  assign dok = DATA_VALID & ~DATA_ERROR;
  assign rd = dok & ~DATA_WRITE;
  assign wr = dok & DATA_WRITE;

  // ----------------------------------------
  // forced event edge
  // ----------------------------------------
  logic agree;
  logic forced_ev;

  assign agree = q.sync[1] == q.sync[2];
  assign forced_ev = agree & q.sync[2] & ~q.forced_lvl;

  // ----------------------------------------
  // event vector
  // ----------------------------------------
  logic [31:0] ev;
  logic any_ev;
  logic ev_a;
  logic ev_b;

  always_comb begin
    ev = `DEC_ZERO_WORD;
    ev[`DEC_B(`DEC_S_IC)] = INSTR_DONE & q.ctrl_a[`DEC_B(`DEC_A_IC)] & ~quiet;
    ev[`DEC_B(`DEC_S_BT)] = BRANCH_TAKEN & q.ctrl_a[`DEC_B(`DEC_A_BT)] & ~quiet;
    ev[`DEC_B(`DEC_S_EXC)] = EXC_TAKEN & q.ctrl_a[`DEC_B(`DEC_A_EXC)]
                             & ~(EXC_CRITICAL & int_mode & ~ext_mode);
    ev[`DEC_B(`DEC_S_TRAP)] = TRAP_TAKEN & q.ctrl_a[`DEC_B(`DEC_A_TRAP)];
    ev[`DEC_B(`DEC_S_FORCED)] = forced_ev;
    ev[`DEC_B(`DEC_S_IA1)] = ia_hit[0];
    ev[`DEC_B(`DEC_S_IA2)] = ia_hit[1];
    ev[`DEC_B(`DEC_S_IA3)] = ia_hit[2];
    ev[`DEC_B(`DEC_S_IA4)] = ia_hit[3];
    ev[`DEC_B(`DEC_S_DR1)] = rd & q.ctrl_b[`DEC_B(`DEC_B_D1R)] & a1 & v1ok;
    ev[`DEC_B(`DEC_S_DW1)] = wr & q.ctrl_b[`DEC_B(`DEC_B_D1W)] & a1 & v1ok;
    ev[`DEC_B(`DEC_S_DR2)] = rd & q.ctrl_b[`DEC_B(`DEC_B_D2R)] & a2 & v2ok;
    ev[`DEC_B(`DEC_S_DW2)] = wr & q.ctrl_b[`DEC_B(`DEC_B_D2W)] & a2 & v2ok;
  end

  assign any_ev = |ev;
  assign ev_a = range_a_en & (ia_hit[0] | ia_hit[1]);
  assign ev_b = range_b_en & (ia_hit[2] | ia_hit[3]);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic [31:0] clr;
  logic wait_mode;

  assign clr = (REG_WR && REG_SEL == `DEC_SEL_STATUS) ? REG_WDATA : `DEC_ZERO_WORD;
  assign wait_mode = ~int_mode & ~ext_mode & WAIT_MODE_EN;

  always_comb begin
    d = q;
    d.sync = {q.sync[1:0], FORCED_EVENT_INPUT};
    if (agree) begin
      d.forced_lvl = q.sync[2];
    end
    // register writes
    if (REG_WR) begin
      unique case (REG_SEL)
        `DEC_SEL_CTRL_A: d.ctrl_a = REG_WDATA & `DEC_CTRL_A_MASK;
        `DEC_SEL_CTRL_B: d.ctrl_b = REG_WDATA & `DEC_CTRL_B_MASK;
        `DEC_SEL_FETCH_ADDR_CMP_1: d.iac[0] = REG_WDATA & `DEC_WORD_MASK;
        `DEC_SEL_FETCH_ADDR_CMP_2: d.iac[1] = REG_WDATA & `DEC_WORD_MASK;
        `DEC_SEL_FETCH_ADDR_CMP_3: d.iac[2] = REG_WDATA & `DEC_WORD_MASK;
        `DEC_SEL_FETCH_ADDR_CMP_4: d.iac[3] = REG_WDATA & `DEC_WORD_MASK;
        `DEC_SEL_DATA_ADDR_CMP_1: d.dac[0] = REG_WDATA;
        `DEC_SEL_DATA_ADDR_CMP_2: d.dac[1] = REG_WDATA;
        `DEC_SEL_VALUE_CMP_WORD_1: d.dvc[0] = REG_WDATA;
        `DEC_SEL_VALUE_CMP_WORD_2: d.dvc[1] = REG_WDATA;
        default: ;
      endcase
    end
    // range toggles
    if (ev_a & flip_a) begin
      d.ctrl_a[`DEC_B(`DEC_A_RAX)] = ~d.ctrl_a[`DEC_B(`DEC_A_RAX)];
    end
    if (ev_b & flip_b) begin
      d.ctrl_a[`DEC_B(`DEC_A_RBX)] = ~d.ctrl_a[`DEC_B(`DEC_A_RBX)];
    end
    // status: set wins over clear
    d.status = (q.status & ~clr) | ev;
    if (any_ev & ~de) begin
      d.status[`DEC_B(`DEC_S_IMP)] = 1'b1;
    end
    // actions
    if (DBG_INTR_ACK) begin
      d.intr = 1'b0;
    end
    if (RESUME) begin
      d.stop = 1'b0;
      d.wstop = 1'b0;
      d.freeze = 1'b0;
    end
    if (EXT_INTR) begin
      d.wstop = 1'b0;
    end
    if (any_ev) begin
      if (int_mode & de) begin
        d.intr = 1'b1;
      end
      if (ext_mode) begin
        d.stop = 1'b1;
      end
      if (wait_mode) begin
        d.wstop = 1'b1;
      end
      if (q.ctrl_a[`DEC_B(`DEC_A_FT)]) begin
        d.freeze = 1'b1;
      end
    end
    // read data
    unique case (REG_SEL)
      `DEC_SEL_CTRL_A: d.rdata = q.ctrl_a;
      `DEC_SEL_CTRL_B: d.rdata = q.ctrl_b;
      `DEC_SEL_STATUS: d.rdata = q.status;
      `DEC_SEL_FETCH_ADDR_CMP_1: d.rdata = q.iac[0];
      `DEC_SEL_FETCH_ADDR_CMP_2: d.rdata = q.iac[1];
      `DEC_SEL_FETCH_ADDR_CMP_3: d.rdata = q.iac[2];
      `DEC_SEL_FETCH_ADDR_CMP_4: d.rdata = q.iac[3];
      `DEC_SEL_DATA_ADDR_CMP_1: d.rdata = q.dac[0];
      `DEC_SEL_DATA_ADDR_CMP_2: d.rdata = q.dac[1];
      `DEC_SEL_VALUE_CMP_WORD_1: d.rdata = q.dvc[0];
      `DEC_SEL_VALUE_CMP_WORD_2: d.rdata = q.dvc[1];
      default: d.rdata = `DEC_ZERO_WORD;
    endcase
    // reset
    if (RST) begin
      d = '0;
      d.status[`DEC_B(`DEC_S_MRR) -: 2] = RESET_KIND;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge CLOCK) begin
    q <= d;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign REG_RDATA = q.rdata;
  assign DBG_INTR_REQ = q.intr;
  assign CORE_STOP = q.stop | q.wstop;
  assign TIMER_FREEZE = q.freeze;
endmodule : dec_event_ctrl

// File: verification/dec_pipe_model.sv
`timescale 1ns/1ps
module dec_pipe_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // answer control
  input wire logic answer_en,
  input wire logic [3:0] lat,
  // block side
  input wire logic req,
  input wire logic stop,
  output logic ack,
  output logic resume
);
  logic [3:0] cnt_q;
  // acknowledge and resume lat+1 cycles after req or stop rises
  always_ff @(posedge clk) begin
    ack <= 1'b0;
    resume <= 1'b0;
    if (rst || !answer_en || !(req || stop)) begin
      cnt_q <= 4'h0;
    end else if (cnt_q == lat) begin
      ack <= req;
      resume <= stop;
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : dec_pipe_model

// File: verification/dec_event_ctrl_properties.sv
`timescale 1ns/1ps
module dec_check (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // registers
  input wire logic REG_WR,
  input wire logic [3:0] REG_SEL,
  input wire logic [31:0] REG_WDATA,
  input wire logic [31:0] REG_RDATA,
  // events
  input wire logic FETCH_VALID,
  input wire logic DATA_VALID,
  input wire logic INSTR_DONE,
  input wire logic BRANCH_TAKEN,
  input wire logic EXC_TAKEN,
  input wire logic TRAP_TAKEN,
  input wire logic FORCED_EVENT_INPUT,
  // actions
  input wire logic DBG_INTR_ALLOW,
  input wire logic DBG_INTR_ACK,
  input wire logic RESUME,
  input wire logic EXT_INTR,
  input wire logic DBG_INTR_REQ,
  input wire logic CORE_STOP,
  input wire logic TIMER_FREEZE
);
  logic [5:0] forced_q;
  logic quiet;
  always_ff @(posedge CLOCK) begin
    forced_q <= {forced_q[4:0], FORCED_EVENT_INPUT};
  end
  assign quiet = !(FETCH_VALID || DATA_VALID || INSTR_DONE || BRANCH_TAKEN || EXC_TAKEN || TRAP_TAKEN)
    && (forced_q == 6'h00);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence s_clear_all;
    REG_WR && REG_SEL == 4'h2 && REG_WDATA == 32'hffff_ffff && quiet;
  endsequence
  sequence s_read_status;
    !REG_WR && REG_SEL == 4'h2;
  endsequence
  a_status_clears: assert property (s_clear_all ##1 s_read_status |=> REG_RDATA == 32'h0)
    else $error("status not cleared");
  a_unmapped_zero: assert property (REG_SEL > 4'ha |=> REG_RDATA == 32'h0)
    else $error("unmapped read not zero");
  a_req_needs_allow: assert property ($rose(DBG_INTR_REQ) |-> $past(DBG_INTR_ALLOW))
    else $error("interrupt without allow");
  a_action_has_cause: assert property ($rose(DBG_INTR_REQ) || $rose(CORE_STOP) || $rose(TIMER_FREEZE)
    |-> !$past(quiet))
    else $error("action without event");
  a_ack_drops_req: assert property (DBG_INTR_ACK && quiet |=> !DBG_INTR_REQ)
    else $error("request kept after ack");
  a_req_holds: assert property (DBG_INTR_REQ && !DBG_INTR_ACK |=> DBG_INTR_REQ)
    else $error("request dropped");
  a_resume_releases: assert property (RESUME && quiet |=> !CORE_STOP && !TIMER_FREEZE)
    else $error("stop kept after resume");
  a_freeze_holds: assert property (TIMER_FREEZE && !RESUME |=> TIMER_FREEZE)
    else $error("freeze dropped");
  a_stop_holds: assert property (CORE_STOP && !RESUME && !EXT_INTR |=> CORE_STOP)
    else $error("stop dropped");
endmodule : dec_check
bind dec_event_ctrl dec_check i_dec_check (
  .CLOCK(CLOCK), .RST(RST), .REG_WR(REG_WR), .REG_SEL(REG_SEL), .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA), .FETCH_VALID(FETCH_VALID), .DATA_VALID(DATA_VALID), .INSTR_DONE(INSTR_DONE),
  .BRANCH_TAKEN(BRANCH_TAKEN), .EXC_TAKEN(EXC_TAKEN), .TRAP_TAKEN(TRAP_TAKEN),
  .FORCED_EVENT_INPUT(FORCED_EVENT_INPUT), .DBG_INTR_ALLOW(DBG_INTR_ALLOW), .DBG_INTR_ACK(DBG_INTR_ACK),
  .RESUME(RESUME), .EXT_INTR(EXT_INTR), .DBG_INTR_REQ(DBG_INTR_REQ), .CORE_STOP(CORE_STOP),
  .TIMER_FREEZE(TIMER_FREEZE)
);

// File: verification/dec_event_ctrl_test.sv
`timescale 1ns/1ps
module dec_event_ctrl_test
  import dec_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, fv = 1'b0, dv = 1'b0, dw = 1'b0, dc = 1'b0, de = 1'b0;
  logic allow = 1'b1, answer_en = 1'b0, ack, resume, req, stop, frz;
  logic crit = 1'b0, wait_en = 1'b0, xi = 1'b0, forced = 1'b0;
  logic [1:0] kind = 2'h2;
  logic [3:0] sel = 4'h0, ev = 4'h0, lat = 4'h1;
  dec_word_t wdata = 32'h0, faddr = 32'h0, daddr = 32'h0, dval = 32'h0, rdata;
  int num_errors = 0, checks_done = 0;
  logic [1:0] md [7] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h1, 2'h1, 2'h1};
  logic [3:0] ln [7] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'h3, 4'hf, 4'hf};
  dec_word_t dd [7] = '{32'h1122_3344, 32'h5566_7744, 32'h5566_7744, 32'h1122_0000,
    32'hffff_3344, 32'h1122_3344, 32'h1122_3344};
  logic hit [7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  always #5 clk = ~clk;
  dec_event_ctrl i_dec_event_ctrl (
    .CLOCK(clk), .RST(rst), .RESET_KIND(kind), .REG_WR(wr), .REG_SEL(sel), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .FETCH_VALID(fv), .FETCH_ADDR(faddr), .INSTR_DONE(ev[3]), .BRANCH_TAKEN(ev[2]),
    .EXC_TAKEN(ev[1]), .EXC_CRITICAL(crit), .TRAP_TAKEN(ev[0]), .FORCED_EVENT_INPUT(forced),
    .DATA_VALID(dv), .DATA_WRITE(dw), .DATA_CACHE_OP(dc), .DATA_ERROR(de), .DATA_ADDR(daddr),
    .DATA_VALUE(dval), .DBG_INTR_ALLOW(allow), .WAIT_MODE_EN(wait_en), .DBG_INTR_ACK(ack),
    .RESUME(resume), .EXT_INTR(xi), .DBG_INTR_REQ(req), .CORE_STOP(stop), .TIMER_FREEZE(frz)
  );
  dec_pipe_model i_dec_pipe_model (
    .clk(clk), .rst(rst), .answer_en(answer_en), .lat(lat), .req(req), .stop(stop), .ack(ack),
    .resume(resume)
  );
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic dec_word_t m(input int n);
    return 32'h8000_0000 >> n;
  endfunction : m
  task automatic check(input dec_word_t got, input dec_word_t exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask : check
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic wreg(input logic [3:0] s, input dec_word_t d);
    sel = s;
    wdata = d;
    wr = 1'b1;
    tick();
    wr = 1'b0;
    tick();
  endtask : wreg
  task automatic rreg(input logic [3:0] s, input dec_word_t e);
    sel = s;
    tick();
    check(rdata, e);
  endtask : rreg
  task automatic fetch(input dec_word_t a);
    faddr = a;
    fv = 1'b1;
    tick();
    fv = 1'b0;
    tick();
  endtask : fetch
  task automatic dref(input logic w, input logic c, input logic e, input dec_word_t a, input dec_word_t v);
    dw = w;
    dc = c;
    de = e;
    daddr = a;
    dval = v;
    dv = 1'b1;
    tick();
    dv = 1'b0;
    tick();
  endtask : dref
  task automatic pulse(input logic [3:0] p);
    ev = p;
    tick();
    ev = 4'h0;
    tick();
  endtask : pulse
  task automatic settle(input logic [3:0] l);
    lat = l;
    answer_en = 1'b1;
    for (int i = 0; i < 40 && {req, stop, frz} !== 3'h0; i++) begin
      tick();
    end
    answer_en = 1'b0;
    if ({req, stop, frz} !== 3'h0) begin
      num_errors++;
      give_verdict();
    end
    wreg(4'h2, 32'hffff_ffff);
  endtask : settle
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 12; i++) begin
      rreg(i[3:0], (i == 2) ? 32'h0000_0200 : 32'h0);
    end
    wreg(4'h2, 32'h0000_0100);
    rreg(4'h2, 32'h0000_0200);
    wreg(4'h2, 32'h0000_0200);
    rreg(4'h2, 32'h0);
  endtask : t_reset
  task automatic t_simple;
    wreg(4'h0, m(0) | m(4) | m(5) | m(6) | m(7));
    for (int i = 0; i < 4; i++) begin
      pulse(4'h8 >> i);
      check({30'h0, req, stop}, 32'h1);
      rreg(4'h2, m(i));
      settle(4'h1 + i[3:0]);
    end
  endtask : t_simple
  task automatic t_fetch;
    wreg(4'h3, 32'h100);
    wreg(4'h4, 32'h200);
    wreg(4'h0, m(1) | m(8));
    fetch(32'h103);
    check({31'h0, req}, 32'h1);
    rreg(4'h2, m(5));
    settle(4'h6);
    wreg(4'h0, m(1) | m(8) | m(10) | m(16));
    fetch(32'h1fc);
    rreg(4'h0, m(1) | m(8) | m(10) | m(11) | m(16));
    settle(4'h1);
    fetch(32'h100);
    rreg(4'h2, 32'h0);
    fetch(32'h200);
    rreg(4'h2, m(5));
    rreg(4'h0, m(1) | m(8) | m(10) | m(16));
    settle(4'h2);
    wreg(4'h5, 32'h400);
    wreg(4'h6, 32'h500);
    wreg(4'h0, m(1) | m(13) | m(14) | m(15));
    fetch(32'h404);
    rreg(4'h2, 32'h0);
    fetch(32'h3fc);
    rreg(4'h2, m(13));
    settle(4'h3);
  endtask : t_fetch
  task automatic t_data;
    wreg(4'h0, m(1));
    wreg(4'h7, 32'h1000);
    wreg(4'h1, m(0) | m(4) | m(5));
    dref(1'b0, 1'b0, 1'b1, 32'h101f, 32'h0);
    dref(1'b1, 1'b0, 1'b0, 32'h101f, 32'h0);
    rreg(4'h2, 32'h0);
    dref(1'b0, 1'b0, 1'b0, 32'h101f, 32'h0);
    rreg(4'h2, m(7));
    settle(4'h2);
    wreg(4'h9, 32'h1122_3344);
    for (int i = 0; i < 7; i++) begin
      wreg(4'h1, m(0) | (dec_word_t'(md[i]) << 18) | (dec_word_t'(ln[i]) << 12));
      dref(1'b0, i == 5, 1'b0, (i == 6) ? 32'h1004 : 32'h1000, dd[i]);
      rreg(4'h2, hit[i] ? m(7) : 32'h0);
      settle(4'h1);
    end
  endtask : t_data
  task automatic t_modes;
    wreg(4'h1, 32'h0);
    wreg(4'h0, m(0) | m(6) | m(31));
    allow = 1'b0;
    pulse(4'h2);
    check({29'h0, req, stop, frz}, 32'h3);
    rreg(4'h2, m(2) | m(11));
    settle(4'h9);
    wreg(4'h0, m(0) | m(1) | m(6));
    allow = 1'b1;
    pulse(4'h2);
    check({29'h0, req, stop, frz}, 32'h6);
    settle(4'h2);
    wreg(4'h0, m(1) | m(6));
    allow = 1'b0;
    pulse(4'h2);
    check({29'h0, req, stop, frz}, 32'h0);
    wreg(4'h0, m(6));
    allow = 1'b1;
    pulse(4'h2);
    check({29'h0, req, stop, frz}, 32'h0);
  endtask : t_modes
  task automatic t_quiet;
    wreg(4'h2, 32'hffff_ffff);
    wreg(4'h0, m(1) | m(4) | m(6));
    crit = 1'b1;
    pulse(4'h2);
    crit = 1'b0;
    allow = 1'b0;
    pulse(4'h8);
    wreg(4'h0, m(1) | m(8) | m(10) | m(16));
    fetch(32'h100);
    allow = 1'b1;
    rreg(4'h2, 32'h0);
    rreg(4'h0, m(1) | m(8) | m(10) | m(16));
    check({31'h0, req}, 32'h0);
  endtask : t_quiet
  task automatic t_wait;
    wreg(4'h0, m(7));
    wait_en = 1'b1;
    pulse(4'h1);
    check({31'h0, stop}, 32'h1);
    xi = 1'b1;
    tick();
    xi = 1'b0;
    tick();
    check({31'h0, stop}, 32'h0);
    wait_en = 1'b0;
    forced = 1'b1;
    repeat (6) tick();
    forced = 1'b0;
    rreg(4'h2, m(3) | m(4));
  endtask : t_wait
  task automatic t_data2;
    wreg(4'h0, 32'h0);
    wreg(4'h2, 32'hffff_ffff);
    wreg(4'h8, 32'h2000);
    wreg(4'ha, 32'h0000_00aa);
    wreg(4'h1, m(3) | m(6) | m(15) | m(23));
    dref(1'b1, 1'b0, 1'b0, 32'h2003, 32'h5555_55aa);
    dref(1'b1, 1'b0, 1'b0, 32'h2004, 32'h5555_55aa);
    rreg(4'h2, m(10));
    wreg(4'h1, m(2) | m(8) | m(9));
    dref(1'b1, 1'b0, 1'b0, 32'h1800, 32'h0);
    dref(1'b1, 1'b0, 1'b0, 32'h2000, 32'h0);
    rreg(4'h2, m(8) | m(10));
  endtask : t_data2
  task automatic t_rereset;
    kind = 2'h1;
    rst = 1'b1;
    tick();
    tick();
    rst = 1'b0;
    check({29'h0, req, stop, frz}, 32'h0);
    rreg(4'h2, 32'h0000_0100);
    rreg(4'h1, 32'h0);
  endtask : t_rereset
  task automatic give_verdict;
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_simple();
    t_fetch();
    t_data();
    t_modes();
    t_quiet();
    t_wait();
    t_data2();
    t_rereset();
    give_verdict();
  end
endmodule : dec_event_ctrl_test
